// ==== core/avsw_ctrl.sv ====
// Write-only two-wire slave and switch control for a video/audio switch.
// Assumes bus lines, straps and disable pin are asynchronous pins; the
// supply monitor pulse arrives on i_bor_pulse. Open-drain data out.
//
// Operation
// R1 - Three strap pins set the low three address bits, high is one.
// R2 - All straps high disables bus addressing, enters pin-controlled mode.
// R3 - Pin mode: data line high selects sources I, low sources II.
// R4 - Pin mode: clock line high gives gain two, low gain one.
// R5 - Pin mode: disable pin high forces all switches off.
// R6 - Address 1001 plus straps; frame is address, direction, ack, byte, ack.
// R7 - Master sends direction zero; no read-back exists.
// R8 - Device pulls acknowledge low after matching address and after data.
// R9 - Bits 7..4 connect audio inputs to audio outputs a and b.
// R10 - Bits 3 and 2 connect video inputs I and II.
// R11 - Bit 1 selects video gain two when set, one when clear.
// R12 - Each switch connects one of two inputs or goes off; bus mode sets both source bits of a switch on when both are written high.
// R13 - Bit 0 clear and disable pin high turns all outputs off.
// R14 - Bit 0 clear, pin low: outputs follow last written bits 7..1.
// R15 - Bit 0 set: disable pin ignored, outputs follow bits 7..1.
// R16 - Power-up reset clears the control byte; switches start off.
// R17 - Brown-out pulse clears the control byte like power-up.
// R18 - Pin mode takes switch positions straight from line levels.
// R19 - New byte applies after its acknowledge; aborted frames change nothing.
// R20 - Reset pulse is accepted as an asynchronous input clearing the byte.
`timescale 1ns/10ps
module avsw_ctrl
    import avsw_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_bor_pulse,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    input  wire logic [2:0]  i_subaddr_strap,
    input  wire logic        i_off_pin,
    output logic             o_sda,
    output logic             o_sda_oe,
    output avsw_switch_type  o_switch,
    output logic             o_pin_mode
);
    typedef struct packed {
        avsw_state_type  state;
        logic [3:0]      count;
        logic [7:0]      shift;
        logic [7:0]      ctrl;
        logic            ack_drive;
        logic            scl_d;
        logic            sda_d;
        logic            bor_d;
        avsw_switch_type sw;
        logic            pin_mode;
    } avsw_ctrl_type;

    avsw_ctrl_type cur;
    avsw_ctrl_type next_cur;

    logic [5:0] sync_out;
    logic       scl_s;
    logic       sda_s;
    logic       off_s;
    logic       bor_s;
    logic [2:0] strap_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic       pin_mode_now;
    logic       gate_off;

    // Every pin, reset pulse included, crosses through two flops.
    // Parked low in reset: a high park faked pin mode and a supply edge.
    avsw_sync #(
        .WIDTH     (6),
        .RESET_VAL (`AVSW_PIN_SYNC_RESET)
    ) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_async   ({i_bor_pulse, i_off_pin, i_subaddr_strap, 1'b1}),
        .o_sync    (sync_out)
    );

    avsw_sync #(
        .WIDTH (2)
    ) u_sync_bus (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_async   ({i_scl, i_sda}),
        .o_sync    ({scl_s, sda_s})
    );

    assign bor_s   = sync_out[5];
    assign off_s   = sync_out[4];
    assign strap_s = sync_out[3:1];

    assign scl_rise     = scl_s & ~cur.scl_d;
    assign scl_fall     = ~scl_s & cur.scl_d;
    assign start_seen   = scl_s & cur.scl_d & cur.sda_d & ~sda_s;
    assign stop_seen    = scl_s & cur.scl_d & ~cur.sda_d & sda_s;
    assign pin_mode_now = (strap_s == `AVSW_STRAP_PIN); // [R2]

    always_comb begin
        next_cur       = cur;
        next_cur.scl_d = scl_s;
        next_cur.sda_d = sda_s;
        next_cur.bor_d = bor_s;
        next_cur.pin_mode = pin_mode_now;
        gate_off = 1'b0;

        if (pin_mode_now) begin
            // Bus logic held idle; lines are read as levels
            next_cur.state     = AVSW_IDLE; // [R2]
            next_cur.ack_drive = 1'b0;
        end else if (start_seen) begin
            next_cur.state     = AVSW_ADDR; // [R6]
            next_cur.count     = `AVSW_CNT_ZERO;
            next_cur.ack_drive = 1'b0;
        end else if (stop_seen) begin
            // Partial byte is dropped, stored byte kept
            next_cur.state     = AVSW_IDLE; // [R19]
            next_cur.ack_drive = 1'b0;
        end else begin
            case (cur.state)
                AVSW_IDLE: begin
                    next_cur.ack_drive = 1'b0;
                end
                AVSW_ADDR: begin
                    if (scl_rise) begin
                        next_cur.shift = {cur.shift[6:0], sda_s};
                        next_cur.count = cur.count + 4'h1;
                    end
                    if (scl_fall && cur.count == `AVSW_CNT_ACK) begin
                        // Only writes to 1001 plus straps are acknowledged
                        if (cur.shift == {`AVSW_ADDR_HI, strap_s, 1'b0}) begin // [R1] [R6] [R7]
                            next_cur.state     = AVSW_AACK;
                            next_cur.ack_drive = 1'b1; // [R8]
                        end else begin
                            next_cur.state = AVSW_IDLE;
                        end
                    end
                end
                AVSW_AACK: begin
                    if (scl_fall) begin
                        next_cur.state     = AVSW_DATA;
                        next_cur.count     = `AVSW_CNT_ZERO;
                        next_cur.ack_drive = 1'b0;
                    end
                end
                AVSW_DATA: begin
                    if (scl_rise) begin
                        next_cur.shift = {cur.shift[6:0], sda_s};
                        next_cur.count = cur.count + 4'h1;
                    end
                    if (scl_fall && cur.count == `AVSW_CNT_ACK) begin
                        next_cur.state     = AVSW_DACK;
                        next_cur.ack_drive = 1'b1; // [R8]
                    end
                end
                AVSW_DACK: begin
                    if (scl_fall) begin
                        // Commit only once the acknowledge clock ends
                        next_cur.ctrl      = cur.shift; // [R19]
                        next_cur.state     = AVSW_IDLE;
                        next_cur.ack_drive = 1'b0;
                    end
                end
                default: begin
                    next_cur.state = AVSW_IDLE;
                end
            endcase
        end

        // Supply pulse clears the byte whatever the bus is doing
        if (bor_s && !cur.bor_d) begin
            next_cur.ctrl      = `AVSW_CTRL_RESET; // [R17] [R20]
            next_cur.state     = AVSW_IDLE;
            next_cur.ack_drive = 1'b0;
        end

        if (pin_mode_now) begin
            gate_off              = off_s; // [R5]
            next_cur.sw.a_src1    = sda_s; // [R3] [R18]
            next_cur.sw.b_src1    = sda_s; // [R3]
            next_cur.sw.v_src1    = sda_s; // [R3]
            next_cur.sw.a_src2    = ~sda_s; // [R3]
            next_cur.sw.b_src2    = ~sda_s; // [R3]
            next_cur.sw.v_src2    = ~sda_s; // [R3]
            next_cur.sw.gain2     = scl_s; // [R4]
        end else begin
            // Gate bit set makes the disable pin irrelevant
            gate_off = ~cur.ctrl[`AVSW_BIT_GATE] & off_s; // [R13] [R15]
            next_cur.sw.a_src1 = cur.ctrl[`AVSW_BIT_AA1]; // [R9] [R14]
            next_cur.sw.a_src2 = cur.ctrl[`AVSW_BIT_AA2]; // [R9]
            next_cur.sw.b_src1 = cur.ctrl[`AVSW_BIT_AB1]; // [R9]
            next_cur.sw.b_src2 = cur.ctrl[`AVSW_BIT_AB2]; // [R9]
            next_cur.sw.v_src1 = cur.ctrl[`AVSW_BIT_V1]; // [R10]
            next_cur.sw.v_src2 = cur.ctrl[`AVSW_BIT_V2]; // [R10]
            next_cur.sw.gain2  = cur.ctrl[`AVSW_BIT_GAIN]; // [R11]
        end
        // Enable low means every output off (high impedance)
        next_cur.sw.enable = ~gate_off; // [R12] [R13]
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            cur.state     <= AVSW_IDLE;
            cur.count     <= `AVSW_CNT_ZERO;
            cur.shift     <= `AVSW_CTRL_RESET;
            cur.ctrl      <= `AVSW_CTRL_RESET; // [R16]
            cur.ack_drive <= 1'b0;
            cur.scl_d     <= 1'b1;
            cur.sda_d     <= 1'b1;
            cur.bor_d     <= 1'b0;
            cur.sw        <= '0; // [R16]
            cur.pin_mode  <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // Open drain: only ever pulls low
    assign o_sda      = 1'b0;
    assign o_sda_oe   = cur.ack_drive;
    assign o_switch   = cur.sw;
    assign o_pin_mode = cur.pin_mode;
endmodule : avsw_ctrl

// ==== core/avsw_params.svh ====
// Constants for the switch control block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef AVSW_PARAMS_SVH
`define AVSW_PARAMS_SVH
`define AVSW_ADDR_HI      4'h9
`define AVSW_CTRL_RESET   8'h00
`define AVSW_STRAP_PIN    3'h7
`define AVSW_BIT_AA1      7
`define AVSW_BIT_AA2      6
`define AVSW_BIT_AB1      5
`define AVSW_BIT_AB2      4
`define AVSW_BIT_V1       3
`define AVSW_BIT_V2       2
`define AVSW_BIT_GAIN     1
`define AVSW_BIT_GATE     0
`define AVSW_CNT_ZERO     4'h0
`define AVSW_CNT_LAST     4'h7
`define AVSW_CNT_ACK      4'h8
// Supply pulse, disable pin and straps park low in reset; constant bit high
`define AVSW_PIN_SYNC_RESET 6'h01
`endif

// ==== core/avsw_pkg.sv ====
// Types shared by the switch control block.
// Assumes avsw_params.svh is on the include path.
`include "avsw_params.svh"
package avsw_pkg;
    typedef struct packed {
        logic a_src1;
        logic a_src2;
        logic b_src1;
        logic b_src2;
        logic v_src1;
        logic v_src2;
        logic gain2;
        logic enable;
    } avsw_switch_type;

    typedef enum logic [4:0] {
        AVSW_IDLE = 5'h01,
        AVSW_ADDR = 5'h02,
        AVSW_AACK = 5'h04,
        AVSW_DATA = 5'h08,
        AVSW_DACK = 5'h10
    } avsw_state_type;
endpackage : avsw_pkg

// ==== core/avsw_sync.sv ====
// Two-flip-flop level synchroniser per bit.
// Assumes inputs are asynchronous to i_sys_clk.
`timescale 1ns/10ps
module avsw_sync
    import avsw_pkg::*;
#(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_resetn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_sys_clk) begin
                if (!i_resetn) begin
                    stage1[g] <= RESET_VAL[g];
                    stage2[g] <= RESET_VAL[g];
                end else begin
                    stage1[g] <= i_async[g];
                    stage2[g] <= stage1[g];
                end
            end
        end
    endgenerate

    assign o_sync = stage2;
endmodule : avsw_sync

// ==== sim/avsw_bus_master.sv ====
// Write-only two-wire bus master model, 125 ns bit period.
// Assumes a pull-up: the bench ANDs its data with the device pull-down.
`timescale 1ns/10ps
module avsw_bus_master (
    input  wire logic i_sda_line,
    output logic      o_scl,
    output logic      o_sda
);
    localparam realtime Q = 31.25;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic clk_bit(input logic b, output logic s);
        #Q o_sda = b;
        #Q o_scl = 1'b1;
        #Q s = i_sda_line;
        #Q o_scl = 1'b0;
    endtask : clk_bit
    // Partial data byte ends in a stop, aborting the frame
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int n,
                        output logic [1:0] ack);
        logic s;
        #Q o_sda = 1'b0;
        #Q o_scl = 1'b0;
        for (int i = 7; i >= 0; i--) clk_bit(a[i], s); // Direction bit last
        clk_bit(1'b1, ack[1]);
        ack[0] = 1'b1;
        for (int i = 7; i > 7 - n; i--) clk_bit(d[i], s);
        if (n == 8) clk_bit(1'b1, ack[0]);
        #Q o_sda = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda = 1'b1;
    endtask : xfer
    task automatic levels(input logic c, input logic s);
        o_scl = c;
        o_sda = s;
    endtask : levels
endmodule : avsw_bus_master

// ==== sim/avsw_ctrl_monitor.sv ====
// Port checker for the switch control block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module avsw_ctrl_monitor
    import avsw_pkg::*;
(
    input wire logic            i_sys_clk,
    input wire logic            i_resetn,
    input wire logic            i_bor_pulse,
    input wire logic            i_scl,
    input wire logic            i_sda,
    input wire logic [2:0]      i_subaddr_strap,
    input wire logic            i_off_pin,
    input wire logic            o_sda,
    input wire logic            o_sda_oe,
    input wire avsw_switch_type o_switch,
    input wire logic            o_pin_mode
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // Six cycles cover the input synchronisers
    a_gate_low_on: assert property ((!i_off_pin)[*6] |-> o_switch.enable)
        else $error("enable low");
    a_pin_src_lvl: assert property ((o_pin_mode && $stable(i_sda))[*6] |->
        o_switch.a_src1 == i_sda && o_switch.b_src2 != i_sda && o_switch.v_src1 == i_sda)
        else $error("pin source");
    a_pin_gain_lvl: assert property ((o_pin_mode && $stable(i_scl))[*6] |->
        o_switch.gain2 == i_scl) else $error("pin gain");
    a_strap_mode: assert property ($stable(i_subaddr_strap)[*5] |->
        o_pin_mode == (i_subaddr_strap == 3'h7)) else $error("mode");
    a_reset_clear: assert property ($rose(i_resetn) |-> o_switch == 8'h00 && !o_sda_oe)
        else $error("not cleared");
    a_ack_slot: assert property ($rose(o_sda_oe) |-> !i_scl && !o_pin_mode)
        else $error("ack slot");
    a_ack_hold: assert property ($rose(o_sda_oe) |-> o_sda_oe[*8] ##0 !o_sda)
        else $error("ack short");
    // Brown-out clears are the only change allowed away from an ack
    a_commit_ack: assert property (!o_pin_mode && !$past(o_pin_mode) &&
        o_switch[7:1] != $past(o_switch[7:1]) |-> $past(o_sda_oe, 6) || o_switch[7:1] == 7'h00)
        else $error("late byte");
endmodule : avsw_ctrl_monitor
bind avsw_ctrl avsw_ctrl_monitor u_mon (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_bor_pulse(i_bor_pulse),
    .i_scl(i_scl), .i_sda(i_sda), .i_subaddr_strap(i_subaddr_strap),
    .i_off_pin(i_off_pin), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .o_switch(o_switch), .o_pin_mode(o_pin_mode)
);

// ==== sim/testbench.sv ====
// Self-checking bench for the switch control block.
// Assumes the bus master model and checker are compiled first.
`timescale 1ns/10ps
module testbench
    import avsw_pkg::*;
;
    logic            i_sys_clk, i_resetn, i_bor_pulse, i_scl, i_off_pin, sda_m, sda_line;
    logic            o_sda, o_sda_oe, o_pin_mode, o;
    logic [2:0]      i_subaddr_strap;
    avsw_switch_type o_switch;
    logic [7:0]      d, last;
    logic [1:0]      ack;
    logic [7:0]      bad [3] = '{8'h96, 8'h95, 8'h84};
    int              seed = 32'h4EDC;
    int              n_errors = 0;
    int              cmp_count = 0;
    int              cycles = 0;
    assign sda_line = sda_m & (o_sda_oe ? o_sda : 1'b1);
    avsw_ctrl u_dut (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_bor_pulse(i_bor_pulse),
        .i_scl(i_scl), .i_sda(sda_line), .i_subaddr_strap(i_subaddr_strap),
        .i_off_pin(i_off_pin), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
        .o_switch(o_switch), .o_pin_mode(o_pin_mode)
    );
    avsw_bus_master u_bm (.i_sda_line(sda_line), .o_scl(i_scl), .o_sda(sda_m));
    function automatic logic [7:0] exp_bus(input logic [7:0] v, input logic off);
        return {v[7:1], ~(off & ~v[0])};
    endfunction : exp_bus
    function automatic logic [7:0] exp_pin(input logic s, input logic c, input logic off);
        return {s, ~s, s, ~s, s, ~s, c, ~off};
    endfunction : exp_pin
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic pins(input logic [2:0] s, input logic off, input int n);
        @(negedge i_sys_clk);
        i_subaddr_strap = s;
        i_off_pin = off;
        repeat (n) @(negedge i_sys_clk);
    endtask : pins
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // Hang guard, well above the few thousand cycles needed
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        i_resetn = 1'b0;
        i_bor_pulse = 1'b0;
        i_off_pin = 1'b0;
        i_subaddr_strap = 3'h0;
        repeat (5) @(negedge i_sys_clk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        chk(o_switch, exp_bus(8'h00, 1'b0));
        $display("done reset");
        for (int k = 0; k < 7; k++) begin
            d = (k == 0) ? 8'hFE : 8'($random(seed));
            o = (k == 0) ? 1'b1 : 1'($random(seed));
            pins(3'(k), o, 6);
            u_bm.xfer({4'h9, 3'(k), 1'b0}, d, 8, ack);
            pins(3'(k), o, 8);
            chk({6'h0, ack}, 8'h00);
            chk(o_switch, exp_bus(d, o));
            pins(3'(k), ~o, 8);
            chk(o_switch, exp_bus(d, ~o));
            last = d;
        end
        $display("done addressing");
        pins(3'h2, 1'b0, 6);
        foreach (bad[j]) begin
            u_bm.xfer(bad[j], ~last, 8, ack);
            chk({6'h0, ack}, 8'h03);
        end
        u_bm.xfer(8'h94, ~last, 4, ack);
        chk({6'h0, ack}, 8'h01);
        pins(3'h2, 1'b0, 8);
        chk(o_switch, exp_bus(last, 1'b0));
        $display("done refusal");
        @(negedge i_sys_clk);
        i_bor_pulse = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        i_bor_pulse = 1'b0;
        repeat (8) @(negedge i_sys_clk);
        chk(o_switch, 8'h01);
        $display("done brown-out");
        for (int i = 0; i < 8; i++) begin
            u_bm.levels(i[1], i[0]);
            pins(3'h7, i[2], 8);
            chk(o_switch, exp_pin(i[0], i[1], i[2]));
        end
        u_bm.xfer(8'h9E, 8'hFF, 8, ack);
        chk({6'h0, ack}, 8'h03);
        $display("done pin mode");
        end_of_test();
    end
endmodule : testbench
